//--- core/rfs_pkg.sv
// Shared constants and types of the regulator fault sequencer
package rfs_pkg;

	// Clock and fault wait timing
	localparam int unsigned CLK_KHZ     = 25000;
	localparam int unsigned OC_WAIT_MS  = 12;
	localparam int unsigned OC_WAIT_CYC = OC_WAIT_MS * CLK_KHZ;

	// Trip retry limit before latch-off
	localparam logic [2:0] RETRY_MAX = 3'h7;

	// Register map (byte addresses)
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 8;
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_EVT   = 8'h08;
	localparam logic [7:0] OFS_MASK  = 8'h0C;

	// Reset values
	localparam logic [7:0] CTRL_RST  = 8'h01;
	localparam logic [5:0] MASK_RST  = 6'h00;

	// Event bit positions
	localparam int unsigned EV_UV    = 0;
	localparam int unsigned EV_OPEN  = 1;
	localparam int unsigned EV_COC   = 2;
	localparam int unsigned EV_NBOC  = 3;
	localparam int unsigned EV_LIM   = 4;
	localparam int unsigned EV_LATCH = 5;
	localparam int unsigned EV_N     = 6;

	// Comparator results from the analog front end
	typedef struct packed {
		logic [1:0] uv_low;       // Rail below target-300mV
		logic [1:0] uv_ok;        // Rail above target-250mV
		logic       open_sense;
		logic       ov_trip;
		logic       core_oc_nom;  // Average above 100uA
		logic       core_oc_ss;   // Average above 140uA
		logic       nb_oc_nom;
		logic       nb_oc_ss;
		logic [3:0] chan_lim;     // Per core channel above 140uA
		logic       enable;
	} rfs_ana_t;

	// Gate drive bundle
	typedef struct packed {
		logic [1:0] upper_gate_drive;
		logic [1:0] lower_gate_drive;
		logic       ext_phase_c_pwm;
		logic       ext_phase_c_oe;
		logic       ext_phase_d_pwm;
		logic       ext_phase_d_oe;
		logic       nb_upper_gate_drive;
		logic       nb_lower_gate_drive;
	} rfs_gate_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_SOFT,
		ST_RUN,
		ST_OC_WAIT,
		ST_OPEN,
		ST_LATCH
	} rfs_state_t;

endpackage

//--- core/rfs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module rfs_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule

//--- core/rfs_sequencer.sv
// Fault protection sequencer for a core and north-bridge buck pair
`timescale 1ns/10ps
// Overview of operation
// R1: Undervoltage only drops power good
// R2: Power good returns above 250mV hysteresis
// R3: Open sense: shut down, restart when cleared
// R4: Averaged current over 100uA trips overcurrent
// R5: Soft-start uses 140uA trip reference
// R6: Core overcurrent: all gates low, power_good_out low
// R7: Wait 12ms, then retry if enabled
// R8: Seventh failed retry latches everything off
// R9: Completed soft-start clears retry counter
// R10: North-bridge trip disables only its drivers; its seventh failed retry latches all gates off
// R11: Overcurrent in power saving restarts normal
// R12: Channel over limit: upper low, lower high
// R13: Upper stays low until current drops
// R14: Latch-off keeps power good low
// R15: Power good low in shutdown, soft-start
// R16: Synchronise every comparator before use
// R17: Wait timed by parameterised clock counter
module rfs_sequencer
	import rfs_pkg::*;
#(
	parameter int unsigned WAIT_CYCLES = rfs_pkg::OC_WAIT_CYC
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire rfs_pkg::rfs_ana_t          ana_i,
	input  wire rfs_pkg::rfs_gate_t         pwm_i,
	input  wire logic                       ss_done_i,
	input  wire logic                       power_saving_select_n_i,
	input  wire logic [rfs_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [rfs_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	output logic      [rfs_pkg::DATA_W-1:0] reg_rdata_o,
	output rfs_pkg::rfs_gate_t              gate_o,
	output logic                            ss_start_o,
	output logic                            ss_active_o,
	output logic                            oc_ref_boost_o,
	output logic                            power_saving_select_n_o,
	output logic                            power_good_out_o,
	output logic                            power_good_pin_o,
	output logic                            power_good_pin_oe_o,
	output logic                            irq_o
);
	import rfs_pkg::*;

	localparam int unsigned CW = $clog2(WAIT_CYCLES + 1);

	rfs_ana_t         s;
	rfs_state_t       state_r;
	rfs_state_t       state_nxt;
	logic [CW-1:0]    wait_cnt_r;
	logic [2:0]       retry_cnt_r;
	logic             nb_only_r;
	logic             uv_flag_r;
	logic             psi_force_r;
	logic             power_good_out_r;
	logic [7:0]       ctrl_r;
	logic [EV_N-1:0]  evt_r;
	logic [EV_N-1:0]  evt_nxt;
	logic [EV_N-1:0]  mask_r;
	logic             open_d_r;
	logic [3:0]       lim_d_r;
	rfs_gate_t        gate_nxt;

	rfs_sync #(
		.W ($bits(rfs_ana_t))
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (ana_i),
		.q_o   (s)
	); // R16

	// Decode of sequencer condition
	wire en_eff     = s.enable & ctrl_r[0];
	wire in_soft    = (state_r == ST_SOFT);
	wire in_run     = (state_r == ST_RUN);
	wire active     = in_soft | in_run;
	wire core_trip  = active & (in_soft ? s.core_oc_ss : s.core_oc_nom); // R4 R5
	wire nb_trip    = active & (in_soft ? s.nb_oc_ss : s.nb_oc_nom); // R10
	wire oc_trip    = core_trip | nb_trip;
	wire retry_last = (retry_cnt_r == RETRY_MAX);
	wire wait_done  = (wait_cnt_r == CW'(WAIT_CYCLES - 1)); // R17
	wire psm_mode   = ~power_saving_select_n_i & ~psi_force_r;
	wire uv_any     = |s.uv_low;
	wire uv_clear   = &s.uv_ok;

	// Register bus decode
	wire wr_ctrl = reg_wr_i & (reg_addr_i == OFS_CTRL);
	wire wr_evt  = reg_wr_i & (reg_addr_i == OFS_EVT);
	wire wr_mask = reg_wr_i & (reg_addr_i == OFS_MASK);
	wire [EV_N-1:0] evt_clr = wr_evt ? reg_wdata_i[EV_N-1:0] : '0;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (en_eff & ~s.open_sense)
					state_nxt = ST_SOFT;
			end
			ST_SOFT, ST_RUN: begin
				if (~en_eff)
					state_nxt = ST_OFF;
				else if (s.ov_trip)
					state_nxt = ST_LATCH; // R14
				else if (s.open_sense)
					state_nxt = ST_OPEN; // R3
				else if (oc_trip)
					state_nxt = retry_last ? ST_LATCH : ST_OC_WAIT; // R8 R10
				else if (in_soft & ss_done_i)
					state_nxt = ST_RUN;
			end
			ST_OC_WAIT: begin
				if (wait_done)
					state_nxt = en_eff ? ST_SOFT : ST_OFF; // R7
			end
			ST_OPEN: begin
				if (~en_eff)
					state_nxt = ST_OFF;
				else if (~s.open_sense)
					state_nxt = ST_SOFT; // R3
			end
			ST_LATCH: state_nxt = ST_LATCH; // R8
			default:  state_nxt = ST_OFF;
		endcase
	end

	// Gate enables; a north-bridge-only trip leaves the core switching
	wire core_on = active | ((state_r == ST_OC_WAIT) & nb_only_r); // R6 R10
	wire nb_on   = active; // R10

	always_comb begin
		gate_nxt = pwm_i;
		for (int i = 0; i < 2; i++) begin
			if (~core_on) begin
				gate_nxt.upper_gate_drive[i] = 1'b0; // R6
				gate_nxt.lower_gate_drive[i] = 1'b0; // R6
			end else if (s.chan_lim[i]) begin
				gate_nxt.upper_gate_drive[i] = 1'b0; // R12 R13
				gate_nxt.lower_gate_drive[i] = 1'b1; // R12
			end
		end
		// External phases are released to high impedance when off
		gate_nxt.ext_phase_c_oe  = core_on & pwm_i.ext_phase_c_oe; // R6
		gate_nxt.ext_phase_d_oe  = core_on & pwm_i.ext_phase_d_oe; // R6
		gate_nxt.ext_phase_c_pwm = core_on & pwm_i.ext_phase_c_pwm
			& ~s.chan_lim[2]; // R12 R13
		gate_nxt.ext_phase_d_pwm = core_on & pwm_i.ext_phase_d_pwm
			& ~s.chan_lim[3]; // R12 R13
		gate_nxt.nb_upper_gate_drive = nb_on & pwm_i.nb_upper_gate_drive;
		gate_nxt.nb_lower_gate_drive = nb_on & pwm_i.nb_lower_gate_drive;
	end

	// Events: set beats a simultaneous write-one clear
	wire [EV_N-1:0] ev_set = {
		(state_nxt == ST_LATCH) & (state_r != ST_LATCH),
		|(s.chan_lim & ~lim_d_r),
		nb_trip,
		core_trip,
		s.open_sense & ~open_d_r,
		uv_any & ~uv_flag_r
	};
	assign evt_nxt = (evt_r & ~evt_clr) | ev_set;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_r != ST_OC_WAIT) begin
			wait_cnt_r <= '0;
		end else if (!wait_done) begin
			wait_cnt_r <= wait_cnt_r + CW'(1); // R17
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			retry_cnt_r <= 3'h0;
			nb_only_r   <= 1'b0;
		end else if (active & en_eff & ~s.ov_trip & ~s.open_sense
			& oc_trip) begin
			retry_cnt_r <= retry_cnt_r + 3'h1; // R8
			nb_only_r   <= nb_trip & ~core_trip; // R10
		end else if (in_soft & ss_done_i & en_eff & ~s.ov_trip
			& ~s.open_sense) begin
			retry_cnt_r <= 3'h0; // R9
		end
	end

	// Only a full reset drops the forced-normal bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			psi_force_r <= 1'b0;
		end else if (oc_trip & ~power_saving_select_n_i) begin
			psi_force_r <= 1'b1; // R11
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uv_flag_r <= 1'b0;
		end else if (uv_any) begin
			uv_flag_r <= 1'b1; // R1
		end else if (uv_clear) begin
			uv_flag_r <= 1'b0; // R2
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_good_out_r  <= 1'b0;
			gate_o   <= '0;
			open_d_r <= 1'b0;
			lim_d_r  <= 4'h0;
		end else begin
			power_good_out_r  <= in_run & (state_nxt == ST_RUN) & ~uv_flag_r; // R14 R15
			gate_o   <= gate_nxt;
			open_d_r <= s.open_sense;
			lim_d_r  <= s.chan_lim;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= CTRL_RST;
			mask_r <= MASK_RST;
			evt_r  <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata_i;
			if (wr_mask)
				mask_r <= reg_wdata_i[EV_N-1:0];
			evt_r <= evt_nxt;
		end
	end

	// Read mux; unmapped addresses read zero
	wire [7:0] stat_word = {uv_flag_r, power_good_out_r, retry_cnt_r, state_r};
	wire [7:0] rd_mux =
		(reg_addr_i == OFS_CTRL) ? ctrl_r :
		(reg_addr_i == OFS_STAT) ? stat_word :
		(reg_addr_i == OFS_EVT)  ? {2'b00, evt_r} :
		(reg_addr_i == OFS_MASK) ? {2'b00, mask_r} : 8'h00;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
		end
	end

	assign ss_start_o     = (state_nxt == ST_SOFT) & ~in_soft;
	assign ss_active_o    = in_soft;
	assign oc_ref_boost_o = in_soft; // R5
	assign power_saving_select_n_o = ~psm_mode; // R11
	assign power_good_out_o    = power_good_out_r;
	assign power_good_pin_o    = 1'b0;
	assign power_good_pin_oe_o = ~power_good_out_r; // R15
	assign irq_o = |(evt_r & mask_r);

	a_uv_drops_power_good_out: // R1
	assert property (@(posedge clk_i) disable iff (rst_i)
		uv_flag_r |=> !power_good_out_o)
	else $error("power good high during undervoltage");

	a_uv_hysteresis: // R2
	assert property (@(posedge clk_i) disable iff (rst_i)
		uv_flag_r && !uv_any && !uv_clear |=> uv_flag_r)
	else $error("undervoltage flag dropped inside hysteresis");

	a_open_shutdown: // R3
	assert property (@(posedge clk_i) disable iff (rst_i)
		active && en_eff && !s.ov_trip && s.open_sense
		|=> state_r == ST_OPEN ##1 !gate_o.upper_gate_drive[0])
	else $error("open sense line did not shut down");

	a_soft_ref_boost: // R5
	assert property (@(posedge clk_i) disable iff (rst_i)
		in_soft && en_eff && !s.ov_trip && !s.open_sense
		&& s.core_oc_nom && !s.core_oc_ss && !nb_trip
		|=> state_r != ST_OC_WAIT)
	else $error("nominal reference used during soft-start");

	a_core_oc_off: // R6
	assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_OC_WAIT && !nb_only_r
		|=> gate_o.upper_gate_drive == 2'b00
		&& gate_o.lower_gate_drive == 2'b00
		&& !gate_o.ext_phase_c_oe && !power_good_out_o)
	else $error("gates active during core overcurrent wait");

	a_wait_length: // R7
	assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_OC_WAIT && state_nxt != ST_OC_WAIT
		|-> wait_cnt_r == CW'(WAIT_CYCLES - 1))
	else $error("overcurrent wait ended early");

	a_latch_hold: // R8
	assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_LATCH |=> state_r == ST_LATCH
		##1 !gate_o.nb_upper_gate_drive && !power_good_out_o)
	else $error("latch-off released without reset");

	a_retry_clear: // R9
	assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_SOFT && state_nxt == ST_RUN |=> retry_cnt_r == 3'h0)
	else $error("retry counter not cleared after soft-start");

	a_chan_limit: // R12
	assert property (@(posedge clk_i) disable iff (rst_i)
		in_run && state_nxt == ST_RUN && s.chan_lim[0]
		|=> !gate_o.upper_gate_drive[0] && gate_o.lower_gate_drive[0])
	else $error("channel limit did not force the gates");

	a_psi_normal: // R11
	assert property (@(posedge clk_i) disable iff (rst_i)
		oc_trip && !power_saving_select_n_i |=> power_saving_select_n_o)
	else $error("power saving mode kept after overcurrent");

	a_nb_only_off: // R10
	assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_OC_WAIT && nb_only_r
		|=> !gate_o.nb_upper_gate_drive
		&& !gate_o.nb_lower_gate_drive)
	else $error("north-bridge gates active during its overcurrent wait");

	a_latch_power_good_out: // R14
	assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_LATCH |=> !power_good_out_o && power_good_pin_oe_o)
	else $error("power good released during latch-off");

	a_soft_power_good_out: // R15
	assert property (@(posedge clk_i) disable iff (rst_i)
		in_soft |=> !power_good_out_o)
	else $error("power good high during soft-start");

	a_ext_limit: // R13
	assert property (@(posedge clk_i) disable iff (rst_i)
		core_on && s.chan_lim[2] |=> !gate_o.ext_phase_c_pwm)
	else $error("external phase switching above its current limit");

endmodule

//--- tb/rfs_stage.sv
// Power stage stand-in: open-drain pull-up and stage activity
`timescale 1ns/10ps
module rfs_stage
	import rfs_pkg::*;
(
	input  wire rfs_pkg::rfs_gate_t g_i,
	input  wire logic               pin_i,
	input  wire logic               oe_i,
	output logic                    pg_o,
	output logic                    core_o,
	output logic                    nb_o
);
	// A released pin floats up through the board pull-up
	assign pg_o   = oe_i ? pin_i : 1'b1;
	assign core_o = |{g_i.upper_gate_drive, g_i.lower_gate_drive};
	assign nb_o   = g_i.nb_upper_gate_drive | g_i.nb_lower_gate_drive;
endmodule

//--- tb/regulator_fault_sequencer_test.sv
// Self-checking bench for the regulator fault sequencer
`timescale 1ns/10ps
module regulator_fault_sequencer_test;
	import rfs_pkg::*;
	localparam int W = 20;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	rfs_ana_t   ana   = '0;
	rfs_gate_t  pwm   = 10'h33E;
	rfs_gate_t  gate;
	logic       done  = 1'b0;
	logic       psi   = 1'b1;
	logic       wr_s  = 1'b0;
	logic       rd_s  = 1'b0;
	logic [7:0] addr  = 8'h00;
	logic [7:0] wd    = 8'h00;
	logic [7:0] rdat;
	logic [7:0] st;
	logic       ss_act, boost, psi_o, pin, oe, irq, pg, c_on, nb_on;
	logic       ss_st, pgo;
	int         errors = 0;
	int         tests_run = 0;
	int         n;
	int         starts = 0;
	always #20 clk_i = ~clk_i;
	// Soft-start request pulses, counted at the edge that takes them
	always @(posedge clk_i) begin
		if (ss_st === 1'b1)
			starts <= starts + 1;
	end
	rfs_sequencer #(.WAIT_CYCLES(W)) dut (
		.clk_i                  (clk_i),
		.rst_i                  (rst_i),
		.ana_i                  (ana),
		.pwm_i                  (pwm),
		.ss_done_i              (done),
		.power_saving_select_n_i(psi),
		.reg_addr_i             (addr),
		.reg_wdata_i            (wd),
		.reg_wr_i               (wr_s),
		.reg_rd_i               (rd_s),
		.reg_rdata_o            (rdat),
		.gate_o                 (gate),
		.ss_start_o             (ss_st),
		.ss_active_o            (ss_act),
		.oc_ref_boost_o         (boost),
		.power_saving_select_n_o(psi_o),
		.power_good_out_o       (pgo),
		.power_good_pin_o       (pin),
		.power_good_pin_oe_o    (oe),
		.irq_o                  (irq)
	);
	rfs_stage stage (
		.g_i   (gate),
		.pin_i (pin),
		.oe_i  (oe),
		.pg_o  (pg),
		.core_o(c_on),
		.nb_o  (nb_on)
	);
	task automatic finish_test;
		$display("compared %0d, mismatched %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, e, input string w);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic fin(input string w);
		$display("test %s done", w);
	endtask
	task automatic hold(input int c);
		repeat (c) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		addr <= a;
		wd   <= d;
		wr_s <= 1'b1;
		@(posedge clk_i);
		wr_s <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_i);
		rd_s <= 1'b0;
		@(negedge clk_i);
		st = rdat;
	endtask
	task automatic wst(input logic [2:0] c);
		for (int i = 0; i < 80; i++) begin
			rd(OFS_STAT);
			if (st[2:0] === c)
				return;
		end
		errors++;
		$display("mismatch state wait expected %h seen %h", c, st[2:0]);
		finish_test();
	endtask
	task automatic up;
		int s0;
		s0 = starts;
		@(posedge clk_i);
		ana.enable <= 1'b1;
		wst(ST_SOFT);
		chk(starts - s0, 1, "soft start pulse");
		chk(boost, 1'b1, "soft boost");
		chk(pg, 1'b0, "soft power_good_out");
		@(posedge clk_i);
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		wst(ST_RUN);
		hold(3);
		chk(boost, 1'b0, "run boost");
		chk(pg, 1'b1, "run power_good_out");
		chk(pgo, 1'b1, "run power_good_out out");
	endtask
	// Fault held through every retry soft-start until latch-off
	task automatic rl(input int k0);
		for (int k = k0; k < 8; k++) begin
			wst(ST_OC_WAIT);
			chk(st[5:3], k[2:0], "retry count");
			// One wait plus one soft-start cycle per retry, less the read
			repeat (W - 1) @(posedge clk_i);
		end
		wst(ST_LATCH);
		chk(c_on | nb_on, 1'b0, "latched gates");
		chk(pg, 1'b0, "latched power_good_out");
		chk(pgo, 1'b0, "latched power_good_out out");
	endtask
	task automatic reset3;
		@(posedge clk_i);
		ana   <= '0;
		rst_i <= 1'b1;
		hold(2);
		@(posedge clk_i);
		rst_i <= 1'b0;
		ana.uv_ok <= 2'b11;
	endtask
	initial begin
		hold(2);
		@(posedge clk_i);
		rst_i <= 1'b0;
		ana.uv_ok <= 2'b11;
		rd(OFS_CTRL);
		chk(st, CTRL_RST, "ctrl reset");
		rd(OFS_MASK);
		chk(st, MASK_RST, "mask reset");
		rd(OFS_EVT);
		chk(st, 8'h00, "event reset");
		rd(OFS_STAT);
		chk(st & 8'h7F, 8'h00, "status reset");
		wr(8'h10, 8'hFF);
		rd(8'h10);
		chk(st, 8'h00, "unmapped");
		chk(pg, 1'b0, "off power_good_out");
		up();
		fin("startup");
		@(posedge clk_i);
		ana.uv_low <= 2'b01;
		ana.uv_ok  <= 2'b00;
		hold(6);
		chk(pg, 1'b0, "uv power_good_out");
		chk(c_on & nb_on, 1'b1, "uv gates");
		@(posedge clk_i);
		ana.uv_low <= 2'b00;
		hold(6);
		chk(pg, 1'b0, "uv hysteresis");
		@(posedge clk_i);
		ana.uv_ok <= 2'b11;
		hold(6);
		chk(pg, 1'b1, "uv recover");
		rd(OFS_STAT);
		chk(st[2:0], ST_RUN, "uv state");
		chk(irq, 1'b0, "irq masked");
		wr(OFS_MASK, 8'h01);
		hold(1);
		chk(irq, 1'b1, "irq raised");
		wr(OFS_EVT, 8'h01);
		hold(1);
		chk(irq, 1'b0, "irq cleared");
		fin("undervoltage");
		@(posedge clk_i);
		ana.chan_lim <= 4'h5;
		hold(6);
		chk(gate.upper_gate_drive, 2'b10, "limit upper");
		chk(gate.lower_gate_drive, 2'b01, "limit lower");
		chk(gate.ext_phase_c_pwm, 1'b0, "limit ext c");
		chk(gate.ext_phase_d_pwm, 1'b1, "limit ext d");
		chk(pg, 1'b1, "limit power_good_out");
		@(posedge clk_i);
		ana.chan_lim <= 4'h0;
		hold(6);
		chk(gate.upper_gate_drive, 2'b11, "limit release");
		chk(gate.ext_phase_c_pwm, 1'b1, "limit ext release");
		fin("channel limit");
		@(posedge clk_i);
		ana.open_sense <= 1'b1;
		wst(ST_OPEN);
		hold(12);
		chk(c_on | nb_on, 1'b0, "open gates");
		rd(OFS_STAT);
		chk(st[2:0], ST_OPEN, "open holds");
		@(posedge clk_i);
		ana.open_sense <= 1'b0;
		up();
		fin("open sense");
		@(posedge clk_i);
		psi <= 1'b0;
		ana.core_oc_nom <= 1'b1;
		ana.core_oc_ss  <= 1'b1;
		for (n = 0; n < 99 && c_on !== 1'b0; n++)
			@(negedge clk_i);
		chk(c_on, 1'b0, "oc gates");
		chk({gate.ext_phase_c_oe, gate.ext_phase_d_oe}, 2'b00, "oc ext");
		chk(pg, 1'b0, "oc power_good_out");
		for (n = 0; n < 99 && ss_act !== 1'b1; n++)
			@(negedge clk_i);
		// Gates drop one edge after the wait starts
		chk(n, W - 1, "oc wait");
		chk(psi_o, 1'b1, "oc normal mode");
		rl(2);
		rd(OFS_EVT);
		chk(st[EV_LATCH], 1'b1, "latch event");
		@(posedge clk_i);
		ana <= '0;
		hold(4);
		@(posedge clk_i);
		ana.enable <= 1'b1;
		hold(10);
		rd(OFS_STAT);
		chk(st[2:0], ST_LATCH, "latch stays");
		reset3();
		up();
		fin("core overcurrent");
		@(posedge clk_i);
		ana.core_oc_nom <= 1'b1;
		wst(ST_SOFT);
		@(posedge clk_i);
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		wst(ST_OC_WAIT);
		chk(st[5:3], 3'h1, "fresh count");
		@(posedge clk_i);
		ana.core_oc_nom <= 1'b0;
		up();
		fin("hiccup");
		@(posedge clk_i);
		ana.nb_oc_nom <= 1'b1;
		ana.nb_oc_ss  <= 1'b1;
		wst(ST_OC_WAIT);
		hold(2);
		chk(nb_on, 1'b0, "nb gates");
		chk(gate.upper_gate_drive, 2'b11, "nb core gates");
		chk(pg, 1'b0, "nb power_good_out");
		rl(1);
		fin("nb overcurrent");
		finish_test();
	end
endmodule
